// ===== design/owd_consts.vh
// constants for the operating watchdog: register map, fields, timing counts
// assumes inclusion by the watchdog design and verification files
`ifndef OWD_CONSTS_VH
`define OWD_CONSTS_VH

// register byte addresses on the axi4-lite port
`define OWD_ADDR_SERVICE   12'hffc
`define OWD_ADDR_CONFIG    12'h000
`define OWD_ADDR_STATUS    12'h004
`define OWD_ADDR_VECTOR    12'h008

// service location index as printed, byte address is four times it
`define OWD_SERVICE_INDEX  16'hffff

// configuration field positions
`define OWD_CFG_DISABLE    0
`define OWD_CFG_RATE       1
`define OWD_CFG_STOPEN     2
`define OWD_CFG_RESET      3'h0

// status field positions
`define OWD_ST_CAUSE       0
`define OWD_ST_WRITTEN     1
`define OWD_ST_RUNNING     2
`define OWD_ST_BLANKMON    3
`define OWD_ST_ILLEGAL     4

// counter widths
`define OWD_PRE_W          12
`define OWD_CNT_W          6

// timing counts in oscillator cycles
`define OWD_LONG_TIMEOUT   262128
`define OWD_SHORT_TIMEOUT  8176
`define OWD_RESET_PULSE    32
`define OWD_POR_DELAY      4096

// reset vector low byte reset value
`define OWD_VECTOR_RESET   8'h00

// axi responses
`define OWD_RESP_OKAY      2'b00
`define OWD_RESP_SLVERR    2'b10

`endif

// ===== design/owd_vector_store.v
// holds the reset vector low byte returned by reads of the service location
// assumes a single clock and a synchronous active-low reset
`timescale 1ns/10ps
`include "owd_consts.vh"

module owd_vector_store
(
  // clock and reset
  input  wire       aclk,
  input  wire       aresetn,
  // write side
  input  wire       wr_en,
  input  wire [7:0] wr_data,
  // registered read data
  output reg  [7:0] rd_data
);

  reg [7:0] vector_byte;

  // store the byte and present it through a register
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      vector_byte <= `OWD_VECTOR_RESET;
      rd_data     <= `OWD_VECTOR_RESET;
    end
    else
    begin
      if (wr_en)
        vector_byte <= wr_data;
      rd_data <= vector_byte;
    end
  end

endmodule

// ===== design/owd_watchdog.v
// operating watchdog: 12-bit prescaler, 6-bit counter, reset generation
// assumes aclk is the oscillator clock, system pins arrive asynchronously
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/10ps
`include "owd_consts.vh"

// Contract
// - twelve-bit prescaler on oscillator clock feeds free-running six-bit counter
// - unserviced timeout asserts system reset after 262128 or 8176 cycles
// - rate select one picks 8176 cycles, zero picks 262128; reset clears
// - any write to service location clears counter and prescaler bits 11..4
// - reading service location returns reset vector low byte
// - timeout drives reset pin low 32 cycles and sets cause flag
// - power-on circuit clears prescaler 4096 cycles after power-up
// - internal reset clears prescaler and counter
// - reset vector fetch clears prescaler
// - stop clears prescaler and halts counting while stopped
// - disable option one disables watchdog, zero enables it
// - options write once after reset, cleared by reset, readable always
// - stop with stop-enable clear becomes illegal opcode reset
// - monitor entry with test voltage disables while voltage remains
// - monitor entry from blank vectors disables until next power-on reset
// - break with test voltage on reset pin disables watchdog
// - keeps counting in wait, timeout in wait still resets
// - never raises an interrupt request, only reset
module owd_watchdog
(
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite write address
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // system events, asynchronous to aclk
  input  wire        power_on,
  input  wire        internal_reset,
  input  wire        vector_fetch,
  input  wire        stop_exec,
  input  wire        stop_mode,
  input  wire        monitor_entry,
  input  wire        blank_vectors,
  input  wire        irq_test_voltage,
  input  wire        rst_test_voltage,
  input  wire        break_state,
  // system outputs
  output reg         reset_pin_n,
  output reg         watchdog_reset,
  output reg         illegal_opcode_reset
);

  // ****************************************
  // input synchronisers
  // ****************************************
  localparam NSYNC = 10;
  wire [NSYNC-1:0] raw_in = {break_state, rst_test_voltage, irq_test_voltage,
                             blank_vectors, monitor_entry, stop_mode, stop_exec,
                             vector_fetch, internal_reset, power_on};
  reg  [NSYNC-1:0] sync_a;
  reg  [NSYNC-1:0] sync_b;
  reg  [NSYNC-1:0] sync_c;

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1)
    begin : g_sync
      // two flops per pin, third only for edge detection
      always @(posedge aclk)
      begin
        if (!aresetn)
        begin
          sync_a[gi] <= 1'b0;
          sync_b[gi] <= 1'b0;
          sync_c[gi] <= 1'b0;
        end
        else
        begin
          sync_a[gi] <= raw_in[gi];
          sync_b[gi] <= sync_a[gi];
          sync_c[gi] <= sync_b[gi];
        end
      end
    end
  endgenerate

  wire s_power   = sync_b[0];
  wire s_intrst  = sync_b[1];
  wire s_fetch_p = sync_b[2] & ~sync_c[2];
  wire s_stop_p  = sync_b[3] & ~sync_c[3];
  wire s_stopped = sync_b[4];
  wire s_mon_p   = sync_b[5] & ~sync_c[5];
  wire s_blank   = sync_b[6];
  wire s_irq_tv  = sync_b[7];
  wire s_rst_tv  = sync_b[8];
  wire s_break   = sync_b[9];
  wire s_power_p = sync_b[0] & ~sync_c[0];

  // ****************************************
  // axi4-lite slave
  // ****************************************
  reg         aw_held;
  reg  [11:0] aw_addr;
  reg         w_held;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;
  reg  [2:0]  cfg;
  reg         cfg_written;
  reg         cause_flag;
  reg         illegal_flag;
  reg         blank_monitor;
  wire        running;
  wire [7:0]  vector_rd;
  reg         rd_pending;
  reg  [11:0] rd_addr;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !rd_pending && !s_axi_rvalid;

  wire wr_go = aw_held && w_held && !s_axi_bvalid;

  // address match for both channels
  function mapped;
    input [11:0] a;
    begin
      mapped = (a == `OWD_ADDR_SERVICE) || (a == `OWD_ADDR_CONFIG) ||
               (a == `OWD_ADDR_STATUS) || (a == `OWD_ADDR_VECTOR);
    end
  endfunction

  wire service_wr = wr_go && (aw_addr == `OWD_ADDR_SERVICE);
  wire config_wr  = wr_go && (aw_addr == `OWD_ADDR_CONFIG) && w_strb[0];
  wire vector_wr  = wr_go && (aw_addr == `OWD_ADDR_VECTOR) && w_strb[0];

  // write channels captured in either order, answered once both are in
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held      <= 1'b0;
      aw_addr      <= 12'h000;
      w_held       <= 1'b0;
      w_data       <= 32'h00000000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `OWD_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[11:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(aw_addr) ? `OWD_RESP_OKAY : `OWD_RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // read: one cycle to let the vector store register its byte
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_pending   <= 1'b0;
      rd_addr      <= 12'h000;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `OWD_RESP_OKAY;
    end
    else
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        rd_pending <= 1'b1;
        rd_addr    <= {s_axi_araddr[11:2], 2'b00};
      end
      if (rd_pending)
      begin
        rd_pending   <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= mapped(rd_addr) ? `OWD_RESP_OKAY : `OWD_RESP_SLVERR;
        case (rd_addr)
          `OWD_ADDR_SERVICE: s_axi_rdata <= {24'h000000, vector_rd};
          `OWD_ADDR_VECTOR:  s_axi_rdata <= {24'h000000, vector_rd};
          `OWD_ADDR_CONFIG:  s_axi_rdata <= {29'h00000000, cfg};
          `OWD_ADDR_STATUS:  s_axi_rdata <= {27'h0000000, illegal_flag,
                                             blank_monitor, running,
                                             cfg_written, cause_flag};
          default:           s_axi_rdata <= 32'h00000000;
        endcase
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  owd_vector_store i_owd_vector_store
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (vector_wr),
    .wr_data (w_data[7:0]),
    .rd_data (vector_rd)
  );

  // ****************************************
  // configuration options
  // ****************************************
  wire sys_reset = s_intrst || watchdog_reset;

  // write-once latches, cleared by any reset
  always @(posedge aclk)
  begin
    if (!aresetn || sys_reset)
    begin
      cfg         <= `OWD_CFG_RESET;
      cfg_written <= 1'b0;
    end
    else if (config_wr && !cfg_written)
    begin
      cfg         <= w_data[2:0];
      cfg_written <= 1'b1;
    end
  end

  wire opt_disable = cfg[`OWD_CFG_DISABLE];
  wire opt_rate    = cfg[`OWD_CFG_RATE];
  wire opt_stopen  = cfg[`OWD_CFG_STOPEN];

  // ****************************************
  // monitor and break gating
  // ****************************************
  reg tv_monitor;

  // blank-vector monitor entry lasts until the next power-on
  always @(posedge aclk)
  begin
    if (!aresetn || s_power_p)
    begin
      blank_monitor <= 1'b0;
      tv_monitor    <= 1'b0;
    end
    else
    begin
      if (s_mon_p && !s_irq_tv && s_blank)
        blank_monitor <= 1'b1;
      if (s_mon_p && s_irq_tv)
        tv_monitor <= 1'b1;
      else if (!s_irq_tv && !s_rst_tv)
        tv_monitor <= 1'b0;
    end
  end

  assign running = !opt_disable && !blank_monitor && !tv_monitor
                   && !(s_break && s_rst_tv) && !s_stopped;

  // ****************************************
  // prescaler and counter
  // ****************************************
  localparam POR_CYC = `OWD_POR_DELAY;
  localparam [5:0] PULSE_LAST = `OWD_RESET_PULSE - 1;        // last count of the pin pulse
  reg [`OWD_PRE_W-1:0] prescaler;
  reg [`OWD_CNT_W-1:0] counter;
  reg [12:0]           por_count;
  reg [5:0]            pulse_count;
  reg                  stop_seen;

  // tap for the counter: the long rate uses the carry out of the full
  // prescaler, the short rate the carry out of its low seven bits;
  // overflow lands after 64 tap periods less the 16 cycles of the uncleared low stages
  wire tap_long  = (prescaler == 12'hfff);
  wire tap_short = (prescaler[6:0] == 7'h7f);
  wire tap       = opt_rate ? tap_short : tap_long;
  wire last_long  = (counter == 6'h3f) && (prescaler == 12'hfef);
  wire last_short = (counter == 6'h3f) && (prescaler[6:0] == 7'h6f);
  wire expire     = running && (opt_rate ? last_short : last_long);

  // the counting chain: resets clear it all, service the counter and prescaler bits 11..4, fetch, stop and power-on the prescaler
  always @(posedge aclk)
  begin
    if (!aresetn || sys_reset)
    begin
      prescaler <= 12'h000;
      counter   <= 6'h00;
    end
    else if (service_wr)
    begin
      prescaler <= {8'h00, prescaler[3:0]};
      counter   <= 6'h00;
    end
    else if (s_fetch_p || s_stop_p || (por_count == POR_CYC[12:0]))
      prescaler <= 12'h000;
    else if (running)
    begin
      prescaler <= prescaler + 12'h001;
      if (tap)
        counter <= counter + 6'h01;
    end
  end

  // power-on delay counter, starts at the power-up edge
  always @(posedge aclk)
  begin
    if (!aresetn || !s_power)
      por_count <= 13'h0000;
    else if (por_count <= POR_CYC[12:0])
      por_count <= por_count + 13'h0001;
  end

  // ****************************************
  // reset outputs
  // ****************************************
  // reset only, never an interrupt request
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      watchdog_reset       <= 1'b0;
      reset_pin_n          <= 1'b1;
      pulse_count          <= 6'h00;
      cause_flag           <= 1'b0;
      illegal_flag         <= 1'b0;
      illegal_opcode_reset <= 1'b0;
      stop_seen            <= 1'b0;
    end
    else
    begin
      stop_seen <= s_stop_p;
      illegal_opcode_reset <= stop_seen && !opt_stopen;
      if (stop_seen && !opt_stopen)
        illegal_flag <= 1'b1;
      if (expire)
      begin
        watchdog_reset <= 1'b1;
        reset_pin_n    <= 1'b0;
        pulse_count    <= 6'h00;
        cause_flag     <= 1'b1;
      end
      else if (!reset_pin_n)
      begin
        if (pulse_count == PULSE_LAST)
        begin
          reset_pin_n    <= 1'b1;
          watchdog_reset <= 1'b0;
        end
        else
          pulse_count <= pulse_count + 6'h01;
      end
      else if (service_wr || !running)
        watchdog_reset <= 1'b0;
    end
  end

endmodule

// ===== verification/owd_watchdog_props.sv
// checker on the watchdog ports: bus answers and reset pulse shape
// assumes the bind at the foot and the shared constants header
`timescale 1ns/10ps
`include "owd_consts.vh"

module owd_watchdog_props
(
  // clock and reset
  input wire        aclk,
  input wire        aresetn,
  // bus
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [1:0]  s_axi_rresp,
  input wire [31:0] s_axi_rdata,
  // system
  input wire        reset_pin_n,
  input wire        watchdog_reset,
  input wire        illegal_opcode_reset
);
  // ****
  // checks
  // ****
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [7:0] low_cnt;
  // length of the current low stretch on the pin
  always @(posedge aclk)
    if (!aresetn || reset_pin_n)
      low_cnt <= 8'h00;
    else
      low_cnt <= low_cnt + 8'h01;
  chk_pulse_len: assert property ($rose(reset_pin_n) |-> low_cnt == 8'h20)
    else $error("reset pulse length wrong");
  chk_pin_pair: assert property (watchdog_reset |-> !reset_pin_n)
    else $error("reset flag without pin low");
  // counter is cleared by the reset, so no instant second pulse
  chk_pin_quiet: assert property ($rose(reset_pin_n) |-> reset_pin_n[*8])
    else $error("pin fell again at once");
  chk_ill_pulse: assert property (illegal_opcode_reset |=> !illegal_opcode_reset)
    else $error("illegal reset longer than a cycle");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  chk_r_delay: assert property (s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
    else $error("read answer late");
  chk_err_zero: assert property (s_axi_rvalid && s_axi_rresp == `OWD_RESP_SLVERR
    |-> s_axi_rdata == 32'h0) else $error("refused read carries data");
endmodule

bind owd_watchdog owd_watchdog_props i_owd_watchdog_props (.aclk, .aresetn,
  .s_axi_arvalid, .s_axi_arready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rresp, .s_axi_rdata, .reset_pin_n,
  .watchdog_reset, .illegal_opcode_reset);

// ===== verification/owd_sys_model.sv
// system side of the watchdog: power, internal reset, vector fetch
// assumes the oscillator clock of the watchdog
`timescale 1ns/10ps

module owd_sys_model
(
  // clock
  input wire   aclk,
  // reset pin from the watchdog
  input wire   reset_pin_n,
  // system events
  output logic power_on = 1'b0,
  output logic internal_reset = 1'b0,
  output logic vector_fetch = 1'b0
);
  // ****
  // behaviour
  // ****
  logic [1:0] up_cnt = 2'h0;
  logic       pin_q = 1'b1;
  // power comes up late; a low pin is echoed as internal reset
  always @(posedge aclk)
  begin
    if (up_cnt != 2'h3)
      up_cnt <= up_cnt + 2'h1;
    power_on       <= (up_cnt == 2'h3);
    internal_reset <= !reset_pin_n;
    pin_q          <= reset_pin_n;
    vector_fetch   <= reset_pin_n && !pin_q; // fetch follows pin release
  end
endmodule

// ===== verification/owd_watchdog_tb.sv
// self-checking bench for the watchdog over its register bus
// assumes the system model drives power and reset feedback
`timescale 1ns/10ps
`include "owd_consts.vh"

module owd_watchdog_tb;
  // ****
  // signals
  // ****
  logic aclk = 0, aresetn = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, rd_d, lowc;
  logic [3:0] s_axi_wstrb = 0;
  logic [1:0] rd_r, wr_r;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, stop_exec = 0, stop_mode = 0;
  logic monitor_entry = 0, blank_vectors = 0, irq_test_voltage = 0;
  logic rst_test_voltage = 0, break_state = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire power_on, internal_reset, vector_fetch;
  wire reset_pin_n, watchdog_reset, illegal_opcode_reset;
  integer miscompares = 0, checks = 0, t;

  owd_watchdog i_owd_watchdog (.*);
  owd_sys_model i_owd_sys_model (.*);

  always #5 aclk = ~aclk;

  // ****
  // tasks
  // ****
  task close_out;
  begin
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask

  task tmo;
  begin
    $display("Error wait expected done seen timeout");
    miscompares++;
    close_out;
  end
  endtask

  task ck(input string nm, input logic [31:0] e, input logic [31:0] s);
  begin
    checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  end
  endtask

  // pin levels are sampled mid-cycle so no edge race exists
  task idle(input integer n);
  begin
    repeat (n)
    begin
      @(negedge aclk);
      if (reset_pin_n !== 1'b1)
        lowc++;
    end
    @(posedge aclk);
  end
  endtask

  // each channel is released on the edge that accepts it, to avoid a double transfer
  task wr(input logic [11:0] a, input logic [31:0] d);
    integer n;
    logic ha, hw, hb;
  begin
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    hb = 1'b0;
    for (n = 0; n < 50 && !hb; n++)
    begin
      @(negedge aclk);
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      hb = s_axi_bvalid;
      wr_r = s_axi_bresp;
      @(posedge aclk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
      if (hb) s_axi_bready <= 1'b0;
    end
    if (!hb) tmo;
    @(posedge aclk);
  end
  endtask

  task rd(input logic [11:0] a);
    integer n;
    logic ha, hr;
  begin
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    hr = 1'b0;
    for (n = 0; n < 50 && !hr; n++)
    begin
      @(negedge aclk);
      ha = s_axi_arvalid && s_axi_arready;
      hr = s_axi_rvalid;
      rd_d = s_axi_rdata;
      rd_r = s_axi_rresp;
      @(posedge aclk);
      if (ha) s_axi_arvalid <= 1'b0;
      if (hr) s_axi_rready <= 1'b0;
    end
    if (!hr) tmo;
    @(posedge aclk);
  end
  endtask

  // ****
  // sequence
  // ****
  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`OWD_ADDR_CONFIG);
    ck("config reset", 32'h0, rd_d);
    wr(`OWD_ADDR_CONFIG, 32'h2);
    wr(`OWD_ADDR_CONFIG, 32'h7);
    rd(`OWD_ADDR_CONFIG);
    ck("config once", 32'h2, rd_d);
    wr(`OWD_ADDR_VECTOR, 32'ha5);
    rd(`OWD_ADDR_SERVICE);
    ck("service read", 32'ha5, rd_d);
    rd(12'h100);
    ck("unmapped resp", 32'(`OWD_RESP_SLVERR), 32'(rd_r));
    wr(12'h100, 32'h0);
    ck("unmapped write", 32'(`OWD_RESP_SLVERR), 32'(wr_r));
    lowc = 0;
    repeat (3)
    begin
      wr(`OWD_ADDR_SERVICE, 32'h5a);
      idle(4000);
    end
    ck("serviced pin", 32'h0, lowc);
    wr(`OWD_ADDR_SERVICE, 32'h0);
    // low prescaler stages survive a service, hence the window
    for (t = 0; t < 9000 && watchdog_reset !== 1'b1; t++)
      @(negedge aclk);
    ck("timeout window", 32'h1, 32'(t >= 8120 && t <= 8180));
    for (t = 0; t < 100 && reset_pin_n !== 1'b1; t++)
      @(negedge aclk);
    ck("pulse length", 32'd32, t);
    @(posedge aclk);
    rd(`OWD_ADDR_STATUS);
    ck("cause flag", 32'h1, 32'(rd_d[`OWD_ST_CAUSE]));
    rd(`OWD_ADDR_CONFIG);
    ck("config cleared", 32'h0, rd_d);
    wr(`OWD_ADDR_CONFIG, 32'h2);
    wr(`OWD_ADDR_SERVICE, 32'h0);
    break_state <= 1'b1;
    rst_test_voltage <= 1'b1;
    lowc = 0;
    idle(9000);
    ck("break pin", 32'h0, lowc);
    break_state <= 1'b0;
    rst_test_voltage <= 1'b0;
    stop_exec <= 1'b1;
    for (t = 0; t < 10 && illegal_opcode_reset !== 1'b1; t++)
      @(negedge aclk);
    ck("illegal stop", 32'h1, 32'(t < 10));
    @(posedge aclk);
    stop_exec <= 1'b0;
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`OWD_ADDR_STATUS);
    ck("cause after reset", 32'h0, 32'(rd_d[`OWD_ST_CAUSE]));
    wr(`OWD_ADDR_CONFIG, 32'h3);
    lowc = 0;
    idle(9000);
    ck("disabled pin", 32'h0, lowc);
    // fresh options: short rate with stop allowed, then halt the count
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    wr(`OWD_ADDR_CONFIG, 32'h6);
    stop_exec <= 1'b1;
    stop_mode <= 1'b1;
    lowc = 0;
    idle(9000);
    ck("stopped pin", 32'h0, lowc);
    rd(`OWD_ADDR_STATUS);
    ck("legal stop", 32'h0, 32'(rd_d[`OWD_ST_ILLEGAL]));
    ck("stopped idle", 32'h0, 32'(rd_d[`OWD_ST_RUNNING]));
    stop_exec <= 1'b0;
    stop_mode <= 1'b0;
    // monitor entry under test voltage holds the count off
    irq_test_voltage <= 1'b1;
    monitor_entry <= 1'b1;
    lowc = 0;
    idle(9000);
    ck("monitor pin", 32'h0, lowc);
    irq_test_voltage <= 1'b0;
    monitor_entry <= 1'b0;
    wr(`OWD_ADDR_SERVICE, 32'h0);
    for (t = 0; t < 9000 && watchdog_reset !== 1'b1; t++)
      @(negedge aclk);
    ck("monitor left", 32'h1, 32'(t < 9000));
    for (t = 0; t < 100 && reset_pin_n !== 1'b1; t++)
      @(negedge aclk);
    // let the echoed internal reset drain before the option write
    repeat (4) @(posedge aclk);
    wr(`OWD_ADDR_CONFIG, 32'h2);
    blank_vectors <= 1'b1;
    monitor_entry <= 1'b1;
    lowc = 0;
    idle(9000);
    ck("blank monitor pin", 32'h0, lowc);
    rd(`OWD_ADDR_STATUS);
    ck("blank monitor flag", 32'h1, 32'(rd_d[`OWD_ST_BLANKMON]));
    close_out;
  end
endmodule
